// *** rcr_pkg.sv ***
// shared constants, bus carriers and helpers of the reset cause recorder
`default_nettype none
package rcr_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int unsigned CLK_NS = 20;                   // system clock period, 50 MHz
    localparam int unsigned HOLD_NS = 320;                 // least width of the system reset pulse
    localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;   // rounds up
    localparam logic [4:0] HOLD_CNT = 5'(HOLD_CYC - 1);    // down-counter load value
    localparam int unsigned LOSS_NS = 100000;              // clock stopped this long counts as lost
    localparam int unsigned LOSS_CYC_DEF = LOSS_NS / CLK_NS; // rounds down
    localparam int unsigned BLANK_CYC = 4;                 // pin readback settle after own drive
    localparam logic [2:0] BLANK_CNT = 3'(BLANK_CYC);

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] OFS_CAUSE = 4'h0;               // reset_cause_and_enable
    localparam logic [3:0] OFS_IRQ_STAT = 4'h4;            // sticky event status, write one to clear
    localparam logic [3:0] OFS_IRQ_MASK = 4'h8;            // event mask

    // ----------------------------------------
    // field positions, shared by cause, status and mask
    // ----------------------------------------
    localparam int BIT_PIN = 0;                            // external_pin_reset_flag
    localparam int BIT_PWR = 1;                            // power_supply_reset_flag
    localparam int BIT_LOSS = 2;                           // clock_loss_enable_flag
    localparam int BIT_WDT = 3;                            // watchdog_reset_flag
    localparam int BIT_SW = 4;                             // software_reset_force_flag
    localparam int BIT_CMP = 5;                            // comparator_reset_enable_flag
    localparam int BIT_FLASH = 6;                          // flash_fault_reset_flag

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [6:0] CAUSE_RST = 7'h02;              // power-on leaves only the supply flag
    localparam logic [6:0] STAT_RST = 7'h00;
    localparam logic [6:0] MASK_RST = 7'h00;
    localparam logic [2:0] SYNC_IDLE = 3'h7;               // pin, supply ok, comparator idle high

    // ----------------------------------------
    // carriers and states
    // ----------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } rcr_avm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } rcr_avm_rsp_t;

    typedef enum logic [0:0] {
        RCR_RUN = 1'b0,                                    // system running
        RCR_HOLD = 1'b1                                    // system reset asserted
    } rcr_seq_t;

    // address decode, used by reads and by every write path
    function automatic logic rcr_hit(input logic [3:0] addr, input logic [3:0] ofs);
        return addr == ofs;
    endfunction

    // one source per reset; supply first since it makes the other flags meaningless
    function automatic logic [6:0] rcr_pick(input logic [6:0] t);
        logic [6:0] p;
        p = 7'h00;
        if (t[BIT_PWR])
            p[BIT_PWR] = 1'b1;
        else if (t[BIT_PIN])
            p[BIT_PIN] = 1'b1;
        else if (t[BIT_LOSS])
            p[BIT_LOSS] = 1'b1;
        else if (t[BIT_WDT])
            p[BIT_WDT] = 1'b1;
        else if (t[BIT_FLASH])
            p[BIT_FLASH] = 1'b1;
        else if (t[BIT_CMP])
            p[BIT_CMP] = 1'b1;
        else if (t[BIT_SW])
            p[BIT_SW] = 1'b1;
        return p;
    endfunction

endpackage
`default_nettype wire

// *** rcr_clock_loss.sv ***
// missing clock detector: flags a monitored clock that stops toggling
`timescale 1ns/1ps
`default_nettype none
module rcr_clock_loss #(
    parameter int unsigned LOSS_CYC = 5000,
    parameter int unsigned LOSS_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic i_core_clk,
    output logic o_loss
);
    import rcr_pkg::*;

    // ----------------------------------------
    // synchroniser, three stages
    // ----------------------------------------
    logic s1_r, s2_r, s3_r; // raw sample chain
    logic lvl_r; // filtered clock level
    logic [LOSS_W-1:0] cnt_r; // cycles since last level change
    logic loss_r; // timeout latched

    // limitation: the monitored clock must be well below half the reference rate
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
        end
        else
        begin
            s1_r <= i_core_clk;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                lvl_r <= s3_r; // change counts only once stages two and three agree
        end
    end

    // ----------------------------------------
    // one-shot timer, retriggered by each edge
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_r <= '0;
            loss_r <= 1'b0;
        end
        else if (!i_enable || (s2_r == s3_r && s3_r != lvl_r))
        begin
            cnt_r <= '0; // disabled or clock moved: restart
            loss_r <= 1'b0;
        end
        else if (cnt_r == LOSS_W'(LOSS_CYC - 1))
            loss_r <= 1'b1; // stuck high or low too long
        else
            cnt_r <= cnt_r + LOSS_W'(1);
    end

    assign o_loss = loss_r & i_enable;

endmodule // rcr_clock_loss
`default_nettype wire

// *** rcr_top.sv ***
// reset cause recorder: cause flags, reset enables, reset sequencing and bus slave
// Notes on behaviour
// - flash fault reset sets bit 6, writes ignored
// - bit 5 written one enables comparator reset
// - bit 5 reads comparator as last cause
// - bit 4 written one forces system reset
// - bit 4 reads one after software reset
// - bit 3 reads watchdog cause, read-only
// - bit 2 enables clock loss detector reset
// - bit 2 reads clock loss as last cause
// - bit 1 written one selects supply monitor
// - bit 1 after power/supply reset; others undefined
// - bit 0 reads external pin reset cause
// - bit 2 zero disables; detector leaves pin alone
// - supply resets only when on and selected
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rcr_top #(
    parameter int unsigned LOSS_CYC = rcr_pkg::LOSS_CYC_DEF, // clock loss timeout in cycles
    parameter int unsigned LOSS_W = 16 // width of the clock loss counter
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire rcr_pkg::rcr_avm_req_t i_avm,
    output var rcr_pkg::rcr_avm_rsp_t o_avm,
    input wire logic i_rst_pin,
    output logic o_rst_pin,
    output logic o_rst_pin_oe_n,
    input wire logic i_supply_on,
    input wire logic i_supply_ok,
    input wire logic i_cmp0_out,
    input wire logic i_wdt_overflow,
    input wire logic i_flash_fault,
    input wire logic i_core_clk,
    output logic o_sys_rst_n,
    output logic o_irq
);
    import rcr_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [2:0] sy1_r, sy2_r, sy3_r; // pin, supply ok, comparator raw samples
    logic [2:0] filt_r; // filtered levels
    logic ack_r; // bus answer phase
    logic req_w; // any request pending
    logic wr_lo_w; // write accepted with low byte lane
    logic [31:0] rdata_r; // read data register
    logic cmp_en_r; // comparator reset enable
    logic loss_en_r; // clock loss detector enable
    logic sup_sel_r; // supply monitor selected as source
    logic loss_w; // detector timeout
    logic sw_fire_w; // software force request
    logic [6:0] trig_w; // live reset sources
    logic [6:0] pick_w; // winning source
    rcr_seq_t state_r; // sequencer state
    logic [4:0] cnt_r; // reset width counter
    logic [6:0] cause_r; // recorded cause flags
    logic sys_rst_n_r; // system reset, active low
    logic drive_n_r; // external pin driver enable, active low
    logic [2:0] blank_r; // pin readback blanking
    logic [6:0] stat_r; // sticky event status
    logic [6:0] mask_r; // event mask
    logic [6:0] stat_clr_w; // write-one-to-clear pattern

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // first stage feeds only the second; a level counts once stages two and three agree
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sy1_r <= SYNC_IDLE;
            sy2_r <= SYNC_IDLE;
            sy3_r <= SYNC_IDLE;
            filt_r <= SYNC_IDLE;
        end
        else
        begin
            sy1_r <= {i_cmp0_out, i_supply_ok, i_rst_pin};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            filt_r <= ((sy2_r ~^ sy3_r) & sy3_r) | ((sy2_r ^ sy3_r) & filt_r);
        end
    end

    // ----------------------------------------
    // bus slave, one wait state on every access
    // ----------------------------------------
    assign req_w = i_avm.read | i_avm.write;
    assign wr_lo_w = i_avm.write & ack_r & i_avm.byteenable[0]; // upper lanes hold nothing

    // answer phase toggles so a held request is taken exactly once
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            ack_r <= 1'b0;
        else
            ack_r <= req_w & ~ack_r;
    end

    // read data captured in the wait cycle, stands at the release edge
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_r <= 32'h0000_0000;
        else if (i_avm.read && !ack_r)
        begin
            if (rcr_hit(i_avm.address, OFS_CAUSE))
                rdata_r <= {25'h000_0000, cause_r}; // bit 7 and up read zero
            else if (rcr_hit(i_avm.address, OFS_IRQ_STAT))
                rdata_r <= {25'h000_0000, stat_r};
            else if (rcr_hit(i_avm.address, OFS_IRQ_MASK))
                rdata_r <= {25'h000_0000, mask_r};
            else
                rdata_r <= 32'h0000_0000; // unmapped reads zero
        end
    end

    // waitrequest high only in the first cycle of a request
    always_comb
    begin
        o_avm.readdata = rdata_r;
        o_avm.waitrequest = req_w & ~ack_r;
    end

    // ----------------------------------------
    // reset source enables
    // ----------------------------------------
    // enables fall back to off on every system reset; software must re-arm
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cmp_en_r <= 1'b0;
            loss_en_r <= 1'b0;
            sup_sel_r <= 1'b0;
        end
        else if (state_r == RCR_HOLD)
        begin
            cmp_en_r <= 1'b0;
            loss_en_r <= 1'b0;
            sup_sel_r <= 1'b0;
        end
        else if (wr_lo_w && rcr_hit(i_avm.address, OFS_CAUSE))
        begin
            cmp_en_r <= i_avm.writedata[BIT_CMP];
            loss_en_r <= i_avm.writedata[BIT_LOSS]; // zero disables
            sup_sel_r <= i_avm.writedata[BIT_PWR];
        end
    end

    // ----------------------------------------
    // clock loss detector
    // ----------------------------------------
    rcr_clock_loss #(
        .LOSS_CYC(LOSS_CYC),
        .LOSS_W(LOSS_W)
    ) u_clock_loss (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_enable(loss_en_r),
        .i_core_clk(i_core_clk),
        .o_loss(loss_w)
    );

    // ----------------------------------------
    // reset sources
    // ----------------------------------------
    // software force acts in the very cycle the write is taken
    assign sw_fire_w = wr_lo_w & rcr_hit(i_avm.address, OFS_CAUSE) & i_avm.writedata[BIT_SW];

    always_comb
    begin
        trig_w = 7'h00;
        trig_w[BIT_PIN] = ~filt_r[0] & (blank_r == 3'h0);
        trig_w[BIT_PWR] = sup_sel_r & i_supply_on & ~filt_r[1]; // on and selected only
        trig_w[BIT_LOSS] = loss_w;
        trig_w[BIT_WDT] = i_wdt_overflow;
        trig_w[BIT_SW] = sw_fire_w;
        trig_w[BIT_CMP] = cmp_en_r & ~filt_r[2]; // active-low comparator
        trig_w[BIT_FLASH] = i_flash_fault;
    end

    assign pick_w = rcr_pick(trig_w);

    // ----------------------------------------
    // reset sequencer and cause record
    // ----------------------------------------
    // power-on starts inside a reset with only the supply flag set
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_r <= RCR_HOLD;
            cnt_r <= HOLD_CNT;
            cause_r <= CAUSE_RST;
            sys_rst_n_r <= 1'b0;
            drive_n_r <= 1'b1;
            blank_r <= 3'h0;
        end
        else
        begin
            if (blank_r != 3'h0)
                blank_r <= blank_r - 3'h1;
            case (state_r)
                RCR_RUN:
                begin
                    if (|trig_w)
                    begin
                        state_r <= RCR_HOLD;
                        cnt_r <= HOLD_CNT;
                        cause_r <= pick_w; // one flag only; writes never reach it
                        sys_rst_n_r <= 1'b0;
                        // pin and clock loss resets leave the pin undriven
                        drive_n_r <= pick_w[BIT_PIN] | pick_w[BIT_LOSS];
                    end
                end
                RCR_HOLD:
                begin
                    if (cnt_r != 5'h00)
                        cnt_r <= cnt_r - 5'h01;
                    else if (filt_r[0] || !cause_r[BIT_PIN])
                    begin
                        // a pin reset lasts as long as the pin is held low
                        state_r <= RCR_RUN;
                        sys_rst_n_r <= 1'b1;
                        drive_n_r <= 1'b1;
                        // own drive still echoes through the synchroniser
                        if (!drive_n_r)
                            blank_r <= BLANK_CNT;
                    end
                end
                default:
                begin
                    state_r <= RCR_RUN;
                    sys_rst_n_r <= 1'b1;
                end
            endcase
        end
    end

    assign o_sys_rst_n = sys_rst_n_r;
    assign o_rst_pin = 1'b0; // open drain: only ever pulls low
    assign o_rst_pin_oe_n = drive_n_r;

    // ----------------------------------------
    // event interrupts
    // ----------------------------------------
    assign stat_clr_w = (wr_lo_w && rcr_hit(i_avm.address, OFS_IRQ_STAT)) ? i_avm.writedata[6:0] : 7'h00;

    // a new event wins over a clear landing in the same cycle
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            stat_r <= STAT_RST;
        else if (state_r == RCR_RUN)
            stat_r <= (stat_r & ~stat_clr_w) | pick_w;
        else
            stat_r <= stat_r & ~stat_clr_w;
    end

    // mask survives system resets so the event is seen after restart
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            mask_r <= MASK_RST;
        else if (wr_lo_w && rcr_hit(i_avm.address, OFS_IRQ_MASK))
            mask_r <= i_avm.writedata[6:0];
    end

    assign o_irq = |(stat_r & mask_r);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);

    sequence s_run_fire;
        state_r == RCR_RUN && |trig_w;
    endsequence

    sequence s_reset_entered;
        state_r == RCR_HOLD && !o_sys_rst_n;
    endsequence

    flash_flag_a: assert property (s_run_fire and pick_w[BIT_FLASH] |=> cause_r == 7'h40)
        else $error("flash fault reset not recorded in bit 6");
    cmp_enable_a: assert property (state_r == RCR_RUN && cmp_en_r && !filt_r[2] |=> s_reset_entered)
        else $error("enabled comparator low did not reset");
    cmp_flag_a: assert property (s_run_fire and pick_w[BIT_CMP] |=> cause_r == 7'h20)
        else $error("comparator reset not recorded in bit 5");
    sw_force_a: assert property (state_r == RCR_RUN && sw_fire_w |=> s_reset_entered ##1 !o_sys_rst_n)
        else $error("software force did not reset at once");
    sw_flag_a: assert property (s_run_fire and pick_w[BIT_SW] |=> cause_r[BIT_SW] && $onehot(cause_r))
        else $error("software reset flag wrong");
    wdt_flag_a: assert property (state_r == RCR_RUN && i_wdt_overflow && !trig_w[BIT_PWR] && !trig_w[BIT_PIN]
        && !trig_w[BIT_LOSS] |=> cause_r == 7'h08)
        else $error("watchdog reset not recorded in bit 3");
    loss_gate_a: assert property (loss_w |-> loss_en_r)
        else $error("clock loss reset while detector disabled");
    loss_flag_a: assert property (s_run_fire and pick_w[BIT_LOSS] |=> cause_r == 7'h04 && o_rst_pin_oe_n)
        else $error("clock loss cause or pin drive wrong");
    sup_sel_a: assert property ($rose(sup_sel_r) |-> $past(wr_lo_w) && $past(i_avm.writedata[BIT_PWR]))
        else $error("supply select set without a write");
    pwr_flag_a: assert property (s_run_fire and pick_w[BIT_PWR] |=> cause_r == 7'h02)
        else $error("supply reset did not record only bit 1");
    pin_flag_a: assert property (s_run_fire and pick_w[BIT_PIN] |=> cause_r == 7'h01 && o_rst_pin_oe_n)
        else $error("pin reset cause or drive wrong");
    loss_pin_a: assert property (state_r == RCR_HOLD && cause_r[BIT_LOSS] |-> o_rst_pin_oe_n)
        else $error("clock loss reset drove the reset pin");
    sup_gate_a: assert property (s_run_fire and !(sup_sel_r && i_supply_on) |=> !cause_r[BIT_PWR])
        else $error("supply reset without enable and select");
    ro_hold_a: assert property (wr_lo_w && state_r == RCR_RUN && !(|trig_w) |=> $stable(cause_r))
        else $error("write changed recorded cause flags");
    hold_width_a: assert property ($fell(o_sys_rst_n) |-> !o_sys_rst_n [*8])
        else $error("system reset pulse too short");
    bus_answer_a: assert property (req_w && o_avm.waitrequest |=> !o_avm.waitrequest)
        else $error("bus answer later than one wait state");

    // ----------------------------------------
    // helper: length of the current system reset pulse
    // ----------------------------------------
    logic [4:0] low_len_r; // cycles the system reset has been low, saturating

    // the repetition above covers only part of the pulse; this counter covers all of it
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
            low_len_r <= 5'h00;
        else if (o_sys_rst_n)
            low_len_r <= 5'h00; // running: restart the count
        else if (low_len_r != 5'h1f)
            low_len_r <= low_len_r + 5'h01;
    end

    hold_full_a: assert property ($rose(o_sys_rst_n) |-> $past(low_len_r) >= 5'(HOLD_CYC - 1))
        else $error("system reset released before its full width");

endmodule // rcr_top
`default_nettype wire

// *** rcr_top_test.sv ***
// self-checking bench of the reset cause recorder
`timescale 1ns/1ps
`default_nettype none
module rcr_top_test;
    import rcr_pkg::*;
    // ----------------------------------------
    // stimulus, observed outputs, bookkeeping
    // ----------------------------------------
    logic i_clk_sys, i_nrst, ext_pin_n, i_supply_on, i_supply_ok, i_cmp0_out;
    logic i_wdt_overflow, i_flash_fault, i_core_clk, core_run;
    logic o_rst_pin, o_rst_pin_oe_n, o_sys_rst_n, o_irq;
    logic [1:0] cdiv; // monitored clock divider
    wire logic pin_wire; // resolved open-drain pin level
    rcr_avm_req_t req;
    rcr_avm_rsp_t rsp;
    logic [31:0] exp_q[$]; // expected read data, oldest first
    logic [31:0] seed;
    int mismatches, n_tests;
    // external pull-down or own drive pulls low, pull-up otherwise
    assign pin_wire = ext_pin_n & (o_rst_pin_oe_n | o_rst_pin);
    rcr_top #(.LOSS_CYC(20), .LOSS_W(16)) i_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_avm(req),
        .o_avm(rsp), .i_rst_pin(pin_wire), .o_rst_pin(o_rst_pin), .o_rst_pin_oe_n(o_rst_pin_oe_n),
        .i_supply_on(i_supply_on), .i_supply_ok(i_supply_ok), .i_cmp0_out(i_cmp0_out),
        .i_wdt_overflow(i_wdt_overflow), .i_flash_fault(i_flash_fault), .i_core_clk(i_core_clk),
        .o_sys_rst_n(o_sys_rst_n), .o_irq(o_irq));
    // ----------------------------------------
    // clocks and helpers
    // ----------------------------------------
    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    // monitored clock at an eighth of the system rate, stoppable
    always @(posedge i_clk_sys)
    begin
        cdiv <= cdiv + 2'h1;
        if (core_run && cdiv == 2'h3)
            i_core_clk <= ~i_core_clk;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read results are matched against the oldest note when the read is taken
    always @(posedge i_clk_sys)
        if (req.read && rsp.waitrequest === 1'b0 && exp_q.size() > 0)
            chk(rsp.readdata, exp_q.pop_front());
    // one bus transfer; request held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] wd, input logic [6:0] ex);
        int n;
        n = 0;
        if (rd)
            exp_q.push_back({25'h0, ex});
        @(posedge i_clk_sys);
        req.read <= rd;
        req.write <= !rd;
        req.address <= a;
        req.writedata <= wd; // whole word, never read-modify-write
        req.byteenable <= 4'hf;
        @(posedge i_clk_sys);
        while (rsp.waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge i_clk_sys);
            n++;
        end
        if (n >= 50)
            mismatches++; // bus answer never came
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic wait_up;
        int n;
        n = 0;
        while (o_sys_rst_n !== 1'b1 && n < 60)
        begin
            @(posedge i_clk_sys);
            n++;
        end
        if (n >= 60)
            mismatches++; // system never came out of reset
    endtask
    // expect a system reset or none; check pin drive while it is held
    task automatic trig(input logic exp_rst, input logic exp_oe);
        int n;
        n = 0;
        while (o_sys_rst_n === 1'b1 && n < 60)
        begin
            @(posedge i_clk_sys);
            n++;
        end
        chk({31'h0, o_sys_rst_n === 1'b0}, {31'h0, exp_rst});
        if (o_sys_rst_n === 1'b0)
        begin
            chk({31'h0, o_rst_pin_oe_n}, {31'h0, exp_oe});
            chk({31'h0, o_rst_pin}, 32'h0);
        end
        wait_up;
    endtask
    task automatic pulse(input logic flash);
        @(posedge i_clk_sys);
        i_wdt_overflow <= !flash;
        i_flash_fault <= flash;
        @(posedge i_clk_sys);
        i_wdt_overflow <= 1'b0;
        i_flash_fault <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // watchdog against a hang
    // ----------------------------------------
    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        mismatches++;
        wrap_up;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {i_nrst, i_supply_on, i_wdt_overflow, i_flash_fault, i_core_clk, cdiv} = '0;
        {ext_pin_n, i_supply_ok, i_cmp0_out, core_run} = 4'hf;
        req = '0;
        seed = 32'he216b881;
        mismatches = 0;
        n_tests = 0;
        repeat (8) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        wait_up;
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h02);
        bus(1'b1, 4'hc, 32'h0, 7'h00);
        bus(1'b0, OFS_IRQ_STAT, 32'h7f, 7'h00);
        bus(1'b0, OFS_IRQ_MASK, 32'h7f, 7'h00);
        $display("test power_on done");
        bus(1'b0, OFS_CAUSE, 32'h10, 7'h00);
        trig(1'b1, 1'b0);
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h10);
        bus(1'b1, OFS_IRQ_STAT, 32'h0, 7'h10);
        chk({31'h0, o_irq}, 32'h1);
        bus(1'b0, OFS_IRQ_STAT, 32'h10, 7'h00);
        @(posedge i_clk_sys);
        chk({31'h0, o_irq}, 32'h0);
        // random bits; only read-only and unused bits may be set
        bus(1'b0, OFS_CAUSE, {rnd() & 32'hffffffc9}, 7'h00);
        trig(1'b0, 1'b1);
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h10);
        $display("test software done");
        bus(1'b0, OFS_IRQ_MASK, 32'h0, 7'h00);
        pulse(1'b0);
        trig(1'b1, 1'b0);
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h08);
        chk({31'h0, o_irq}, 32'h0);
        bus(1'b0, OFS_IRQ_MASK, 32'h08, 7'h00);
        @(posedge i_clk_sys);
        chk({31'h0, o_irq}, 32'h1);
        bus(1'b0, OFS_IRQ_STAT, 32'h7f, 7'h00);
        pulse(1'b1);
        trig(1'b1, 1'b0);
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h40);
        $display("test watchdog_flash done");
        @(posedge i_clk_sys);
        ext_pin_n <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        ext_pin_n <= 1'b1;
        trig(1'b1, 1'b1);
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h01);
        i_cmp0_out <= 1'b0;
        trig(1'b0, 1'b1);
        i_cmp0_out <= 1'b1;
        repeat (8) @(posedge i_clk_sys); // let the high level pass the synchroniser first
        bus(1'b0, OFS_CAUSE, 32'h20, 7'h00);
        i_cmp0_out <= 1'b0;
        trig(1'b1, 1'b0);
        i_cmp0_out <= 1'b1;
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h20);
        $display("test pin_comparator done");
        bus(1'b0, OFS_CAUSE, 32'h04, 7'h00);
        bus(1'b0, OFS_CAUSE, 32'h00, 7'h00);
        core_run <= 1'b0;
        trig(1'b0, 1'b1);
        core_run <= 1'b1;
        repeat (16) @(posedge i_clk_sys);
        bus(1'b0, OFS_CAUSE, 32'h04, 7'h00);
        core_run <= 1'b0;
        trig(1'b1, 1'b1);
        core_run <= 1'b1;
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h04);
        $display("test clock_loss done");
        // monitor on but not selected: a low supply must not reset
        i_supply_ok <= 1'b0;
        i_supply_on <= 1'b1;
        bus(1'b0, OFS_CAUSE, 32'h00, 7'h00);
        trig(1'b0, 1'b1);
        i_supply_ok <= 1'b1;
        repeat (8) @(posedge i_clk_sys); // monitor settles before it is selected
        bus(1'b0, OFS_CAUSE, 32'h02, 7'h00);
        i_supply_ok <= 1'b0;
        trig(1'b1, 1'b0);
        i_supply_ok <= 1'b1;
        bus(1'b1, OFS_CAUSE, 32'h0, 7'h02);
        $display("test supply done");
        wrap_up;
    end
endmodule // rcr_top_test
`default_nettype wire
